// ### rtl/analog_to_pwm_modulator.sv
// Analog to PWM modulator with AXI4-Lite configuration
// Contract
// RULE1: Fixed source selected means the constant register replaces the analog input.
// RULE2: Input constant spans 0 to 65535, resets to zero.
// RULE3: Lower bound spans 0 to 65535, resets to zero.
// RULE4: Upper bound spans 1 to 65535, resets to 65535.
// RULE5: Period settable 0.2 s to 6553.5 s, default 2 s.
// RULE6: High time is period times (in - min) over (max - min).
// RULE7: Low time fills the rest of the period.
// RULE8: No high or low phase shorter than 0.1 s.
// RULE9: High time under 0.1 s keeps output low.
// RULE10: Low time under 0.1 s keeps output high.
// RULE11: Input above max forces high, below min forces low.
// RULE12: Phases timed in 0.1 s ticks, period starts high, sampled per period.
// RULE13: Input clamped to bounds, computed at 40-bit precision.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "pwm_mod_params.svh"
module analog_to_pwm_modulator #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clock, // 100 MHz clock
  input wire logic srst, // Sync reset, active high
  input wire logic [15:0] analog_in, // Internal analog value
  output logic pwm_out, // Modulated output
  input wire logic [11:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI aw valid
  output logic s_axi_awready, // AXI aw ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI byte strobes
  input wire logic s_axi_wvalid, // AXI w valid
  output logic s_axi_wready, // AXI w ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI b valid
  input wire logic s_axi_bready, // AXI b ready
  input wire logic [11:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI ar valid
  output logic s_axi_arready, // AXI ar ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI r valid
  input wire logic s_axi_rready // AXI r ready
);
  typedef struct packed {
    pwm_mod_pkg::cfg_s cfg;
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] tick_cnt;
    logic tick;
    pwm_mod_pkg::phase_e phase;
    logic [15:0] ph_cnt;
    logic [15:0] high_t;
    logic [15:0] low_t;
    logic [15:0] next_high;
    logic [15:0] next_low;
    logic next_force;
    logic next_level;
    logic force_r;
    logic calc_busy;
    logic div_start;
    logic [39:0] div_num;
    logic [15:0] div_den;
    logic [15:0] per_s;
    logic [15:0] ain;
    logic out;
  } st_s;

  st_s s_r, s_nxt;
  logic [39:0] quo;
  logic div_done;
  logic [15:0] sel_in;
  logic [15:0] clamped;
  logic [31:0] wmask;
  logic wr_fire;
  logic [31:0] rd_val;
  logic [1:0] rd_resp;
  logic [15:0] hi_q;

  pwm_divider #(.NW(40), .DW(16)) u_div (
    .clock(clock),
    .srst(srst),
    .start(s_r.div_start),
    .num(s_r.div_num),
    .den(s_r.div_den),
    .quo(quo),
    .done(div_done)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_comb begin
    s_nxt = s_r;
    // Same-clock source: one register stage, no synchroniser
    s_nxt.ain = analog_in;
    sel_in = s_r.cfg.fixed_src ? s_r.cfg.const_in : s_r.ain; // RULE1
    clamped = sel_in; // RULE13
    if (sel_in < s_r.cfg.in_min) begin
      clamped = s_r.cfg.in_min;
    end else if (sel_in > s_r.cfg.in_max) begin
      clamped = s_r.cfg.in_max;
    end
    // Saturate; the clamped input keeps the quotient within the period anyway
    hi_q = (quo[39:16] != 24'h000000) ? 16'hffff : quo[15:0];
    wmask = {{8{s_r.wstrb[3]}}, {8{s_r.wstrb[2]}}, {8{s_r.wstrb[1]}}, {8{s_r.wstrb[0]}}};
    wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    rd_val = 32'h00000000;
    rd_resp = 2'b00;

    // Write channel, address and data taken in either order
    s_nxt.awready = !s_r.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_r.w_got;
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
      s_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
      s_nxt.wready = 1'b0;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.awready = 1'b0;
      s_nxt.wready = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = 2'b00;
      case (s_r.awaddr)
        `ADDR_CTRL: s_nxt.cfg.fixed_src = s_r.wstrb[0] ? s_r.wdata[`CTRL_SRC_BIT]
                                                          : s_r.cfg.fixed_src;
        `ADDR_CONST: s_nxt.cfg.const_in = 16'(merge({16'h0000, s_r.cfg.const_in}, s_r.wdata,
                                                    wmask)); // RULE2
        `ADDR_MIN: s_nxt.cfg.in_min = 16'(merge({16'h0000, s_r.cfg.in_min}, s_r.wdata,
                                                wmask)); // RULE3
        `ADDR_MAX: begin
          rd_val = merge({16'h0000, s_r.cfg.in_max}, s_r.wdata, wmask);
          // Zero upper bound is out of range; refused with SLVERR
          if (rd_val[15:0] == 16'h0000) begin
            s_nxt.bresp = 2'b10;
          end else begin
            s_nxt.cfg.in_max = rd_val[15:0]; // RULE4
          end
        end
        `ADDR_PERIOD: begin
          rd_val = merge({16'h0000, s_r.cfg.period}, s_r.wdata, wmask);
          if (rd_val[15:0] < `PERIOD_TICKS_MIN) begin
            s_nxt.bresp = 2'b10;
          end else begin
            s_nxt.cfg.period = rd_val[15:0]; // RULE5
          end
        end
        `ADDR_STATUS: s_nxt.bresp = 2'b10;
        default: s_nxt.bresp = 2'b11;
      endcase
    end

    // Read channel
    // Cleared again: the write path borrows rd_val for merging
    rd_val = 32'h00000000;
    s_nxt.arready = !s_r.rvalid && !s_r.arready;
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      case (s_axi_araddr)
        `ADDR_CTRL: rd_val = {31'h00000000, s_r.cfg.fixed_src};
        `ADDR_CONST: rd_val = {16'h0000, s_r.cfg.const_in};
        `ADDR_MIN: rd_val = {16'h0000, s_r.cfg.in_min};
        `ADDR_MAX: rd_val = {16'h0000, s_r.cfg.in_max};
        `ADDR_PERIOD: rd_val = {16'h0000, s_r.cfg.period};
        `ADDR_STATUS: rd_val = {29'h00000000, (s_r.phase == pwm_mod_pkg::ph_high),
                                s_r.force_r, s_r.out};
        default: rd_resp = 2'b11;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_val;
      s_nxt.rresp = rd_resp;
    end

    // 0.1 s time base
    s_nxt.tick = 1'b0; // RULE12
    if (s_r.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = 32'h00000000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 32'h00000001;
    end

    // Background computation of the next period's split; result sampled at period start
    s_nxt.div_start = 1'b0;
    if (!s_r.calc_busy) begin
      s_nxt.calc_busy = 1'b1;
      s_nxt.per_s = s_r.cfg.period;
      if (sel_in > s_r.cfg.in_max) begin
        s_nxt.calc_busy = 1'b0;
        s_nxt.next_force = 1'b1; // RULE11
        s_nxt.next_level = 1'b1;
      end else if (sel_in < s_r.cfg.in_min || s_r.cfg.in_max <= s_r.cfg.in_min) begin
        s_nxt.calc_busy = 1'b0;
        s_nxt.next_force = 1'b1; // RULE11
        s_nxt.next_level = 1'b0;
      end else begin
        s_nxt.div_start = 1'b1; // RULE13
        s_nxt.div_num = 40'(s_r.cfg.period) * 40'(clamped - s_r.cfg.in_min);
        s_nxt.div_den = s_r.cfg.in_max - s_r.cfg.in_min;
      end
    end else if (div_done) begin
      s_nxt.calc_busy = 1'b0;
      s_nxt.next_high = hi_q; // RULE6
      s_nxt.next_low = s_r.per_s - hi_q; // RULE7
      s_nxt.next_force = 1'b0;
      if (hi_q < `MIN_PHASE_TICKS) begin
        s_nxt.next_force = 1'b1; // RULE9
        s_nxt.next_level = 1'b0;
      end else if (s_r.per_s - hi_q < `MIN_PHASE_TICKS) begin
        s_nxt.next_force = 1'b1; // RULE10
        s_nxt.next_level = 1'b1;
      end
    end

    // Phase sequencer; a forced level is re-evaluated each tick
    if (s_r.tick) begin
      case (s_r.phase)
        pwm_mod_pkg::ph_high: begin
          if (s_r.ph_cnt + 16'h0001 >= s_r.high_t) begin
            s_nxt.phase = pwm_mod_pkg::ph_low; // RULE8
            s_nxt.ph_cnt = 16'h0000;
            s_nxt.out = 1'b0; // RULE7
          end else begin
            s_nxt.ph_cnt = s_r.ph_cnt + 16'h0001;
          end
        end
        pwm_mod_pkg::ph_low: begin
          if (s_r.ph_cnt + 16'h0001 >= s_r.low_t) begin
            s_nxt.phase = pwm_mod_pkg::ph_const;
          end else begin
            s_nxt.ph_cnt = s_r.ph_cnt + 16'h0001;
          end
        end
        pwm_mod_pkg::ph_const: s_nxt.phase = pwm_mod_pkg::ph_const;
        default: s_nxt.phase = pwm_mod_pkg::ph_const;
      endcase
      if (s_nxt.phase == pwm_mod_pkg::ph_const) begin
        // Period start: take the latest computed split
        s_nxt.ph_cnt = 16'h0000; // RULE12
        s_nxt.high_t = s_r.next_high;
        s_nxt.low_t = s_r.next_low;
        s_nxt.force_r = s_r.next_force;
        if (s_r.next_force) begin
          s_nxt.out = s_r.next_level; // RULE9 RULE10 RULE11
          s_nxt.phase = pwm_mod_pkg::ph_const;
        end else begin
          s_nxt.out = 1'b1; // RULE6
          s_nxt.phase = pwm_mod_pkg::ph_high;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
      s_r.cfg.const_in <= `CONST_IN_RST;
      s_r.cfg.in_min <= `IN_MIN_RST;
      s_r.cfg.in_max <= `IN_MAX_RST;
      s_r.cfg.period <= `PERIOD_TICKS_RST;
      s_r.phase <= pwm_mod_pkg::ph_const;
      s_r.next_force <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pwm_out = s_r.out;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;
endmodule : analog_to_pwm_modulator

// ### rtl/pwm_mod_params.svh
// Constants for the analog to PWM modulator
`ifndef PWM_MOD_PARAMS_SVH
`define PWM_MOD_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define TICK_TIME_MS 100
`define TICK_CYCLES ((`TICK_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define CONST_IN_RST 16'h0000
`define IN_MIN_RST 16'h0000
`define IN_MAX_RST 16'hffff
`define PERIOD_TICKS_RST 16'h0014
`define PERIOD_TICKS_MIN 16'h0002
`define MIN_PHASE_TICKS 16'h0001
`define ADDR_CTRL 12'h000
`define ADDR_CONST 12'h004
`define ADDR_MIN 12'h008
`define ADDR_MAX 12'h00c
`define ADDR_PERIOD 12'h010
`define ADDR_STATUS 12'h014
`define CTRL_SRC_BIT 0
`define STAT_OUT_BIT 0
`define STAT_FORCE_BIT 1
`define STAT_PHASE_BIT 2
`endif

// ### rtl/pwm_mod_pkg.sv
// Types for the analog to PWM modulator
package pwm_mod_pkg;
  typedef enum logic [1:0] {ph_high, ph_low, ph_const} phase_e;
  typedef struct packed {
    logic fixed_src;
    logic [15:0] const_in;
    logic [15:0] in_min;
    logic [15:0] in_max;
    logic [15:0] period;
  } cfg_s;
  typedef struct packed {
    logic [3:0] pad;
    logic [39:0] num;
    logic [15:0] den;
  } div_req_s;
endpackage : pwm_mod_pkg

// ### rtl/pwm_divider.sv
// Restoring divider for the high time computation
`timescale 1ns/10ps
`include "pwm_mod_params.svh"
module pwm_divider #(
  parameter int NW = 40,
  parameter int DW = 16
) (
  input wire logic clock, // System clock
  input wire logic srst, // Sync reset
  input wire logic start, // Begin divide
  input wire logic [NW-1:0] num, // Dividend
  input wire logic [DW-1:0] den, // Divisor, nonzero
  output logic [NW-1:0] quo, // Quotient
  output logic done // One-cycle done pulse
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [6:0] cnt;
    logic [NW-1:0] q;
    logic [DW:0] rem;
    logic [DW-1:0] d;
  } st_s;
  st_s s_r, s_nxt;
  logic [DW:0] trial;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    trial = '0;
    if (start && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = 7'(NW);
      s_nxt.q = num;
      s_nxt.rem = '0;
      s_nxt.d = den;
    end else if (s_r.busy) begin
      trial = {s_r.rem[DW-1:0], s_r.q[NW-1]};
      s_nxt.q = {s_r.q[NW-2:0], 1'b0};
      if (trial >= {1'b0, s_r.d}) begin
        s_nxt.rem = trial - {1'b0, s_r.d};
        s_nxt.q[0] = 1'b1;
      end else begin
        s_nxt.rem = trial;
      end
      s_nxt.cnt = s_r.cnt - 7'h01;
      if (s_r.cnt == 7'h01) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign quo = s_r.q;
  assign done = s_r.done;
endmodule : pwm_divider

// ### tb/pwm_src_model.sv
// Model of the internal analog value source
`timescale 1ns/10ps
module pwm_src_model (
  input wire logic clock, // Clock
  input wire logic [15:0] level, // Requested value
  output logic [15:0] value // Value fed to the modulator
);
  // Updates once a clock, like a sampled converter
  always_ff @(posedge clock) begin
    value <= level;
  end
endmodule : pwm_src_model

// ### tb/pwm_mod_monitor.sv
// Port-level assertions for the modulator
`timescale 1ns/10ps
module pwm_mod_monitor #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clock, // Clock
  input wire logic srst, // Sync reset
  input wire logic pwm_out, // Output
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  logic prev_r;
  int run_r;
  // Cycles since the output last changed
  always_ff @(posedge clock) begin
    prev_r <= pwm_out;
    run_r <= (srst || prev_r != pwm_out) ? 0 : run_r + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  rst_quiet_a: assert property ($fell(srst) |-> !pwm_out && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  phase_min_a: assert property (prev_r != pwm_out |-> run_r >= TICK_CYCLES - 1)
    else $error("output phase shorter than one tick");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  aw_once_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  w_once_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("write data ready held");
  ar_once_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_legal_a: assert property (s_axi_bvalid |-> s_axi_bresp != 2'b01)
    else $error("exclusive okay on write");
endmodule : pwm_mod_monitor
bind analog_to_pwm_modulator pwm_mod_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_pwm_mod_monitor (
  .clock(clock), .srst(srst), .pwm_out(pwm_out), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ### tb/analog_to_pwm_modulator_tb_top.sv
// Self-checking bench for the modulator
`timescale 1ns/10ps
module analog_to_pwm_modulator_tb_top;
  localparam int T = 10;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [15:0] level = 16'h0000;
  logic [15:0] analog_in;
  logic pwm_out;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_rdata;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total = 0;
  int tests_run = 0;
  always #5 clock = ~clock;
  pwm_src_model i_pwm_src_model (.clock(clock), .level(level), .value(analog_in));
  analog_to_pwm_modulator #(.TICK_CYCLES(T)) i_analog_to_pwm_modulator (
    .clock(clock), .srst(srst), .analog_in(analog_in), .pwm_out(pwm_out),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge clock);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    check(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata, ed);
    check(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Reference high time in ticks
  function automatic int exp_hi(int x, int mn, int mx, int p);
    longint h;
    if (x > mx) return p;
    if (x < mn || mx <= mn) return 0;
    h = (longint'(p) * (x - mn)) / (mx - mn);
    if (h < 1) return 0;
    if (p - h < 1) return p;
    return int'(h);
  endfunction : exp_hi

  // High cycles over whole periods do not depend on where counting starts
  task automatic run_case(input int src, input int cst, input int x, input int mn,
                          input int mx, input int p);
    int seen;
    int e;
    seen = 0;
    @(posedge clock);
    level <= x[15:0];
    wr(12'h000, src, 2'b00);
    wr(12'h004, cst, 2'b00);
    wr(12'h008, mn, 2'b00);
    wr(12'h00c, mx, 2'b00);
    wr(12'h010, p, 2'b00);
    repeat (500) @(posedge clock);
    repeat (2 * p * T) begin
      @(posedge clock);
      seen += (pwm_out === 1'b1);
    end
    e = exp_hi(src ? cst : x, mn, mx, p);
    check(seen, 2 * T * e);
    // Forced levels show in status: out, forced, not in high phase
    if (e == p) begin
      rd(12'h014, 32'h00000003, 2'b00);
    end else if (e == 0) begin
      rd(12'h014, 32'h00000002, 2'b00);
    end
  endtask : run_case

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    wrap_up();
  end

  initial begin
    void'($urandom(4123));
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rd(12'h000, 32'h00000000, 2'b00);
    rd(12'h004, 32'h00000000, 2'b00);
    rd(12'h008, 32'h00000000, 2'b00);
    rd(12'h00c, 32'h0000ffff, 2'b00);
    rd(12'h010, 32'h00000014, 2'b00);
    wr(12'h00c, 32'h00000000, 2'b10);
    wr(12'h010, 32'h00000001, 2'b10);
    wr(12'h014, 32'h00000000, 2'b10);
    wr(12'h01c, 32'h00000000, 2'b11);
    rd(12'h01c, 32'h00000000, 2'b11);
    s_axi_wstrb <= 4'h2;
    wr(12'h004, 32'h0000abcd, 2'b00);
    s_axi_wstrb <= 4'hf;
    rd(12'h004, 32'h0000ab00, 2'b00);
    rd(12'h00c, 32'h0000ffff, 2'b00);
    run_case(0, 0, 32'h8000, 0, 32'hffff, 4);
    run_case(0, 0, 100, 0, 32'hffff, 2);
    run_case(0, 0, 32'hffff, 0, 32'hffff, 20);
    run_case(0, 0, 300, 100, 200, 10);
    run_case(0, 0, 50, 100, 200, 10);
    run_case(1, 150, 0, 100, 200, 10);
    run_case(0, 0, 199, 100, 200, 20);
    for (int i = 0; i < 6; i++) begin
      run_case(0, 0, $urandom_range(32'hffff), 32'h1000, 32'hf000, $urandom_range(20, 2));
    end
    // Mid-run reset must bring back defaults and a quiet output
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    check(pwm_out, 32'h00000000);
    rd(12'h004, 32'h00000000, 2'b00);
    rd(12'h008, 32'h00000000, 2'b00);
    rd(12'h010, 32'h00000014, 2'b00);
    wrap_up();
  end
endmodule : analog_to_pwm_modulator_tb_top
